//--- verilog/dpct_pkg.sv
// Package: register map, field layout and timing constants for the dual counter/timers
package dpct_pkg;
	localparam logic [7:0] DPCT_TMR_ADDR = 8'hf1;
	localparam logic [7:0] DPCT_CNT1_ADDR = 8'hf2;
	localparam logic [7:0] DPCT_SECOND_PRESCALE_ADDR = 8'hf3;
	localparam logic [7:0] DPCT_CNT0_ADDR = 8'hf4;
	localparam logic [7:0] DPCT_FIRST_PRESCALE_ADDR = 8'hf5;
	localparam logic [7:0] DPCT_PORT3_CFG_ADDR = 8'he0;
	localparam logic [7:0] DPCT_IRQ_STAT_ADDR = 8'he1;
	localparam logic [7:0] DPCT_IRQ_MASK_ADDR = 8'he2;
	localparam logic [7:0] DPCT_PORT3_DATA_ADDR = 8'he3;
	// Timer mode control fields
	localparam int DPCT_TMR_LOAD0 = 0;
	localparam int DPCT_TMR_RUN0 = 1;
	localparam int DPCT_TMR_LOAD1 = 2;
	localparam int DPCT_TMR_RUN1 = 3;
	localparam int DPCT_TMR_TIN_LO = 4;
	localparam int DPCT_TMR_TIN_HI = 5;
	// Prescaler fields
	localparam int DPCT_PRE_AUTO = 0;
	localparam int DPCT_PRE_EXTCLK = 1;
	localparam int DPCT_PRE_DIV_LO = 2;
	localparam int DPCT_PRE_DIV_HI = 7;
	// Port 3 configuration fields
	localparam int DPCT_P3_ANALOG = 0;
	localparam int DPCT_P3_CMP_TIN = 1;
	// Interrupt status bits
	localparam int DPCT_IRQ_T0 = 0;
	localparam int DPCT_IRQ_T1 = 1;
	localparam int DPCT_IRQ_EXT_LO = 2;
	localparam logic [7:0] DPCT_RESET_BYTE = 8'h00;
	localparam logic [1:0] DPCT_TIN_EXTCLK = 2'h0;
	localparam logic [1:0] DPCT_TIN_GATE = 2'h1;
	localparam logic [1:0] DPCT_TIN_TRIG_NR = 2'h2;
	localparam logic [1:0] DPCT_TIN_TRIG_RE = 2'h3;
	localparam logic [1:0] DPCT_INT_DIV = 2'h3;
endpackage

//--- verilog/dpct_channel.sv
// One counter channel: prescaler plus 8-bit down counter
`timescale 1ns/1ps
module dpct_channel
	import dpct_pkg::*;
#(
	parameter int CW = 8,
	parameter int PW = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic load,
	input wire logic auto_reload,
	input wire logic [PW-1:0] pre_div,
	input wire logic [CW-1:0] init_val,
	// State
	output logic [CW-1:0] count,
	output logic expire
);
	logic [PW-1:0] pre_cnt;
	logic [CW-1:0] next_count;
	logic done;
	// A zero prescale wraps through 63 down to 1, so it divides by 64
	wire pre_end = (pre_cnt == {{(PW-1){1'b0}}, 1'b1});
	wire cnt_end = (count == {{(CW-1){1'b0}}, 1'b1});
	// A finished one-shot must not wrap past zero
	wire step = run && tick && pre_end && !done;
	// Zero in a field means the full range: 64 and 256 fall out of wrap-around
	always_comb begin
		next_count = count - {{(CW-1){1'b0}}, 1'b1};
		if (step && cnt_end && auto_reload)
			next_count = init_val;
	end
	always_ff @(posedge clk) begin
		if (reset || load) begin
			pre_cnt <= pre_div;
			count <= reset ? '0 : init_val;
			expire <= 1'b0;
			done <= 1'b0;
		end else begin
			expire <= step && cnt_end;
			if (step && cnt_end && !auto_reload)
				done <= 1'b1;
			if (run && tick)
				pre_cnt <= pre_end ? pre_div : pre_cnt - {{(PW-1){1'b0}}, 1'b1};
			if (step)
				count <= next_count;
		end
	end
endmodule

//--- verilog/dpct_top.sv
// Top: dual prescaled counter/timers with port 3 input logic and register file
// Summary of operation
// - Two 8-bit counters each with 6-bit prescaler
// - Second prescaler internal or external; first internal only
// - Prescaler divides source by 1 to 64
// - Counter decrements loaded value 1 to 256
// - End of count raises that timer's request
// - Start, stop, continue, or reload from initial
// - One-shot halts at zero; auto-reload repeats
// - Counters readable undisturbed; prescalers write-only
// - Second source: clock divided by four or pin
// - Timer input as clock, triggers, or gate
// - Timers and external inputs run during halt
// - Comparator feeds interrupts, port data, timer input
// - Port 3 lines digital or analog comparator
// - Comparator 2 both edges; comparator 1 falling
// - Comparators off frees reference line as input
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module dpct_top
	import dpct_pkg::*;
#(
	parameter int CW = 8,
	parameter int PW = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Port 3 lines: digital level and comparator outputs
	input wire logic [2:0] port3_pin,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	// Requests
	output logic first_timer_request,
	output logic second_timer_request,
	output logic [3:0] external_interrupt_requests,
	output logic irq
);
	logic [7:0] timer_mode_control, first_prescale, second_prescale;
	logic [CW-1:0] first_init, second_init;
	logic [1:0] port3_cfg;
	logic [5:0] irq_stat, irq_mask;
	logic [2:0] p3_prev;
	logic [1:0] div4;
	logic trig_run, tin_prev;
	logic [CW-1:0] first_count, second_count;
	logic first_exp, second_exp;

	// Input selection: analog mode swaps the comparators in
	wire analog = port3_cfg[DPCT_P3_ANALOG];
	wire first_in = analog ? cmp1_out : port3_pin[0];
	wire second_in = analog ? cmp2_out : port3_pin[1];
	wire ref_in = port3_pin[2];
	wire [2:0] p3_now = {ref_in, second_in, first_in};
	wire external_timer_input = (analog && !port3_cfg[DPCT_P3_CMP_TIN]) ? port3_pin[0] : first_in;
	// Edges on port 3 inputs
	wire fall1 = p3_prev[0] && !p3_now[0];
	wire edge2 = p3_prev[1] ^ p3_now[1];
	wire rise2 = !p3_prev[1] && p3_now[1];
	wire fall3 = p3_prev[2] && !p3_now[2];
	wire [3:0] ext_ev = {analog ? edge2 : rise2, analog ? 1'b0 : fall3, fall1, fall1 & ~analog};

	// Timer input modes
	wire [1:0] tin_mode = timer_mode_control[DPCT_TMR_TIN_HI:DPCT_TMR_TIN_LO];
	wire tin_fall = tin_prev && !external_timer_input;
	wire int_tick = (div4 == DPCT_INT_DIV);
	wire ext_src = second_prescale[DPCT_PRE_EXTCLK];
	wire trig_mode = (tin_mode == DPCT_TIN_TRIG_NR) || (tin_mode == DPCT_TIN_TRIG_RE);
	// Only trigger modes may arm, or a stale run flag blocks the first trigger later
	wire retrig = tin_fall && trig_mode && ((tin_mode == DPCT_TIN_TRIG_RE) || !trig_run);
	wire second_tick = (ext_src && tin_mode == DPCT_TIN_EXTCLK) ? tin_fall :
		(ext_src && tin_mode == DPCT_TIN_GATE) ? (int_tick && external_timer_input) :
		(ext_src && trig_mode) ? (int_tick && trig_run) : int_tick;
	wire second_run = timer_mode_control[DPCT_TMR_RUN1] && !(ext_src && trig_mode && !trig_run);
	wire second_load = (wr && addr == DPCT_TMR_ADDR && wdata[DPCT_TMR_LOAD1]) || (ext_src && trig_mode && retrig);
	wire first_load = wr && addr == DPCT_TMR_ADDR && wdata[DPCT_TMR_LOAD0];

	// Register decode
	wire [5:0] events = {ext_ev, second_exp, first_exp};
	wire [5:0] clr = (wr && addr == DPCT_IRQ_STAT_ADDR) ? wdata[5:0] : 6'h00;
	wire [7:0] next_rdata = (addr == DPCT_TMR_ADDR) ? timer_mode_control :
		(addr == DPCT_CNT1_ADDR) ? second_count :
		(addr == DPCT_CNT0_ADDR) ? first_count :
		(addr == DPCT_PORT3_CFG_ADDR) ? {6'h00, port3_cfg} :
		(addr == DPCT_IRQ_STAT_ADDR) ? {2'h0, irq_stat} :
		(addr == DPCT_IRQ_MASK_ADDR) ? {2'h0, irq_mask} :
		(addr == DPCT_PORT3_DATA_ADDR) ? {5'h00, p3_now} : DPCT_RESET_BYTE;

	// Both channels run off clk alone, never the CPU clock, so halt leaves them going
	dpct_channel #(.CW(CW), .PW(PW)) u_first (
		.clk(clk), .reset(reset), .tick(int_tick),
		.run(timer_mode_control[DPCT_TMR_RUN0]), .load(first_load),
		.auto_reload(first_prescale[DPCT_PRE_AUTO]),
		.pre_div(first_prescale[DPCT_PRE_DIV_HI:DPCT_PRE_DIV_LO]),
		.init_val(first_init), .count(first_count), .expire(first_exp)
	);
	dpct_channel #(.CW(CW), .PW(PW)) u_second (
		.clk(clk), .reset(reset), .tick(second_tick), .run(second_run), .load(second_load),
		.auto_reload(second_prescale[DPCT_PRE_AUTO]),
		.pre_div(second_prescale[DPCT_PRE_DIV_HI:DPCT_PRE_DIV_LO]),
		.init_val(second_init), .count(second_count), .expire(second_exp)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			timer_mode_control <= DPCT_RESET_BYTE;
			first_prescale <= DPCT_RESET_BYTE;
			second_prescale <= DPCT_RESET_BYTE;
			first_init <= '0;
			second_init <= '0;
			port3_cfg <= 2'h0;
			irq_mask <= 6'h00;
		end else if (wr) begin
			// Load bits are write actions and never stick; run bits are stored and stay set
			if (addr == DPCT_TMR_ADDR)
				timer_mode_control <= wdata & 8'hfa;
			if (addr == DPCT_FIRST_PRESCALE_ADDR)
				first_prescale <= wdata;
			if (addr == DPCT_SECOND_PRESCALE_ADDR)
				second_prescale <= wdata;
			if (addr == DPCT_CNT0_ADDR)
				first_init <= wdata;
			if (addr == DPCT_CNT1_ADDR)
				second_init <= wdata;
			if (addr == DPCT_PORT3_CFG_ADDR)
				port3_cfg <= wdata[1:0];
			if (addr == DPCT_IRQ_MASK_ADDR)
				irq_mask <= wdata[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat <= 6'h00;
			p3_prev <= p3_now; // Start from the pin level, so reset makes no false edge
			div4 <= 2'h0;
			tin_prev <= 1'b0;
			trig_run <= 1'b0;
			rdata <= DPCT_RESET_BYTE;
			first_timer_request <= 1'b0;
			second_timer_request <= 1'b0;
			external_interrupt_requests <= 4'h0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~clr) | events; // Set wins over clear
			p3_prev <= p3_now;
			div4 <= div4 + 2'h1;
			tin_prev <= external_timer_input;
			// One-shot trigger ends when the second counter expires
			if (retrig)
				trig_run <= 1'b1;
			else if (second_exp && !second_prescale[DPCT_PRE_AUTO])
				trig_run <= 1'b0;
			rdata <= rd ? next_rdata : DPCT_RESET_BYTE;
			first_timer_request <= first_exp;
			second_timer_request <= second_exp;
			external_interrupt_requests <= ext_ev;
			irq <= |(irq_stat & irq_mask);
		end
	end
endmodule

//--- verif/dpct_tin_model.sv
// Partner: pulse source on the external timer input line
`timescale 1ns/1ps
module dpct_tin_model (
	input wire logic clk,
	output logic tin
);
	initial tin = 1'b1;
	// Low phase of w clocks, high phase of w+1 between pulses; w of 2 or more keeps the input period legal
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			@(posedge clk) tin <= 1'b0;
			repeat (w) @(posedge clk);
			tin <= 1'b1;
			repeat (w) @(posedge clk);
		end
	endtask
endmodule

//--- verif/dpct_asserts.sv
// Checker: assertions on the counter/timer top ports
`timescale 1ns/1ps
module dpct_asserts
	import dpct_pkg::*;
#(parameter int CW = 8, parameter int PW = 6) (
	// Bus, pins and requests
	input wire logic clk, reset, wr, rd, cmp1_out, cmp2_out,
	input wire logic [7:0] addr, wdata, rdata,
	input wire logic [2:0] port3_pin,
	input wire logic first_timer_request, second_timer_request, irq,
	input wire logic [3:0] external_interrupt_requests
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata without read");
	AST_FIRST_PRESCALE_WO: assert property (rd && addr == DPCT_FIRST_PRESCALE_ADDR |=> rdata == 8'h00) else $error("first_prescale read");
	AST_SECOND_PRESCALE_WO: assert property (rd && addr == DPCT_SECOND_PRESCALE_ADDR |=> rdata == 8'h00) else $error("second_prescale read");
	AST_UNMAPPED: assert property (rd && addr == 8'h00 |=> rdata == 8'h00) else $error("unmapped read");
	// Fastest internal step is one per four clocks, so requests never come closer unless the second timer counts pin falls
	AST_T0_GAP: assert property (first_timer_request |=> !first_timer_request [*3]) else $error("t0 gap");
	AST_T1_GAP: assert property (second_timer_request |=> !second_timer_request [*3]) else $error("t1 gap");
	AST_MODE_RB: assert property ((wr && addr == DPCT_TMR_ADDR) ##2 (rd && addr == DPCT_TMR_ADDR)
		|=> (rdata & 8'h3a) == ($past(wdata, 3) & 8'h3a)) else $error("mode readback");
	AST_EXT_PULSE: assert property (external_interrupt_requests[0] |=> !external_interrupt_requests[0])
		else $error("ext pulse");
endmodule
bind dpct_top dpct_asserts #(.CW(CW), .PW(PW)) u_chk (.clk, .reset, .wr, .rd, .cmp1_out, .cmp2_out, .addr,
	.wdata, .rdata, .port3_pin, .first_timer_request, .second_timer_request, .irq, .external_interrupt_requests);

//--- verif/dpct_top_tb.sv
// Testbench: self-checking run of the dual counter/timers
`timescale 1ns/1ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("BAD %0t %s", $time, m); end end
module dpct_top_tb;
	import dpct_pkg::*;
	logic clk = 0, reset = 1, wr = 0, rd = 0, tin, cmp1_out = 0, cmp2_out = 0, t0r, t1r, irq;
	logic [7:0] addr = 0, wdata = 0, rdata, d;
	logic [3:0] ext;
	int err_total = 0, cmp_count = 0, n;
	logic [7:0] iv[4] = '{8'h03, 8'h05, 8'h01, 8'h00};
	logic [7:0] pv[4] = '{8'h05, 8'h09, 8'h01, 8'h05};
	int ep[4] = '{12, 40, 256, 1024};
	dpct_top DUT (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .port3_pin({2'b11, tin}), .cmp1_out, .cmp2_out,
		.first_timer_request(t0r), .second_timer_request(t1r), .external_interrupt_requests(ext), .irq);
	dpct_tin_model u_tin (.clk, .tin);
	initial forever #5 clk = ~clk;
	task automatic wreg(input logic [7:0] a, v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic wreq(input bit t);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((t ? t1r : t0r) !== 1'b1 && n < 3000);
	endtask
	task automatic t_regs;
		rreg(DPCT_CNT0_ADDR);
		`CHK(d, DPCT_RESET_BYTE, "reset count")
		wreg(DPCT_SECOND_PRESCALE_ADDR, 8'hff);
		wreg(8'h00, 8'h5a);
		rreg(8'h00);
		`CHK(d, 8'h00, "unmapped read")
		rreg(DPCT_SECOND_PRESCALE_ADDR);
		`CHK(d, 8'h00, "prescale readable")
		for (int m = 0; m < 4; m++) begin
			wreg(DPCT_TMR_ADDR, 8'(m << 4));
			rreg(DPCT_TMR_ADDR);
			`CHK(d, 8'(m << 4), "mode readback")
		end
	endtask
	task automatic t_period;
		for (int t = 0; t < 2; t++) begin
			for (int i = 0; i < 4; i++) begin
				wreg(t ? DPCT_CNT1_ADDR : DPCT_CNT0_ADDR, iv[i]);
				wreg(t ? DPCT_SECOND_PRESCALE_ADDR : DPCT_FIRST_PRESCALE_ADDR, pv[i]);
				wreg(DPCT_TMR_ADDR, t ? 8'h0c : 8'h03);
				wreq(t[0]);
				wreq(t[0]);
				`CHK(n, ep[i], "reload period")
			end
		end
		wreg(DPCT_TMR_ADDR, 8'h00);
	endtask
	task automatic t_stop;
		logic [7:0] a;
		wreg(DPCT_CNT0_ADDR, 8'hc8);
		wreg(DPCT_FIRST_PRESCALE_ADDR, 8'h04);
		wreg(DPCT_TMR_ADDR, 8'h03);
		repeat (40) @(posedge clk);
		wreg(DPCT_TMR_ADDR, 8'h00);
		rreg(DPCT_CNT0_ADDR);
		a = d;
		rreg(DPCT_CNT0_ADDR);
		`CHK(d, a, "stopped count moved")
		wreg(DPCT_TMR_ADDR, 8'h02);
		repeat (20) @(posedge clk);
		wreg(DPCT_TMR_ADDR, 8'h00);
		rreg(DPCT_CNT0_ADDR);
		`CHK(a - d >= 8'd5 && a - d <= 8'd6, 1'b1, "no continue")
		wreg(DPCT_TMR_ADDR, 8'h01);
		rreg(DPCT_CNT0_ADDR);
		`CHK(d, 8'hc8, "reload value")
		`CHK(a < 8'hc8, 1'b1, "no counting")
		wreg(DPCT_CNT0_ADDR, 8'h02);
		wreg(DPCT_TMR_ADDR, 8'h03);
		repeat (40) @(posedge clk);
		rreg(DPCT_CNT0_ADDR);
		`CHK(d, 8'h00, "one-shot not halted")
	endtask
	task automatic t_irq;
		`CHK(irq, 1'b0, "masked irq")
		wreg(DPCT_IRQ_MASK_ADDR, 8'h01);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b1, "irq low")
		wreg(DPCT_IRQ_STAT_ADDR, 8'h01);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0, "irq stuck")
		rreg(DPCT_IRQ_STAT_ADDR);
		`CHK(d[1:0], 2'b10, "status")
	endtask
	task automatic t_ext;
		wreg(DPCT_CNT1_ADDR, 8'h02);
		wreg(DPCT_SECOND_PRESCALE_ADDR, 8'h06);
		wreg(DPCT_TMR_ADDR, 8'h0c);
		fork
			u_tin.pulse(2, 4);
			wreq(1'b1);
		join
		`CHK(n > 8 && n < 3000, 1'b1, "ext clock count")
		rreg(DPCT_IRQ_STAT_ADDR);
		`CHK(d[2], 1'b1, "pin edge event")
		fork
			u_tin.pulse(1, 2);
			begin
				repeat (2) @(negedge clk);
				`CHK(ext, 4'h3, "first pin fall")
				@(negedge clk);
				`CHK(ext, 4'h0, "event not a pulse")
			end
		join
		wreg(DPCT_TMR_ADDR, 8'h00);
	endtask
	task automatic t_cmp;
		@(posedge clk);
		cmp1_out <= 1;
		cmp2_out <= 1;
		wreg(DPCT_PORT3_CFG_ADDR, 8'h01);
		@(posedge clk);
		cmp2_out <= 0;
		repeat (2) @(negedge clk);
		`CHK(ext, 4'h8, "comparator 2 edge")
		@(posedge clk);
		cmp1_out <= 0;
		repeat (2) @(negedge clk);
		`CHK(ext, 4'h2, "comparator 1 fall")
		rreg(DPCT_PORT3_DATA_ADDR);
		`CHK(d, 8'h04, "comparator port data")
	endtask
	task automatic stop_test;
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		t_regs;
		t_period;
		t_irq;
		t_stop;
		t_ext;
		t_cmp;
		stop_test;
	end
	initial begin
		#500000;
		err_total++;
		stop_test;
	end
endmodule
